// ---- rtl/hisc_regs.svh ----
// Register offsets, field positions, reset values and command codes
// Assumes inclusion by the design and verification modules by bare name
`ifndef HISC_REGS_SVH
`define HISC_REGS_SVH

// ==========================================
// Host register offsets (byte addresses)
`define HISC_OFS_AUTO_ACK 8'h56
`define HISC_OFS_STATUS_CMD 8'h5e
`define HISC_OFS_INT_MASK 8'h5a

// ==========================================
// Local bus addresses of the card-side registers
`define HISC_LOC_MAC_STATUS 24'hcde08
`define HISC_LOC_MAILBOX 24'hcde0b
`define HISC_LOC_MAILBOX_MASK 24'hffff9f
`define HISC_LOC_OP_LSB 5

// ==========================================
// Interrupt status bit positions
`define HISC_ST_LATCH 0
`define HISC_ST_HOST_ERR 1
`define HISC_ST_TX_DONE 2
`define HISC_ST_INT_REQ 6
`define HISC_ST_MAC_FAULT 7
`define HISC_ST_DOWNLOAD 9
`define HISC_ST_UPLOAD 10
`define HISC_ST_STARVED 11
`define HISC_ST_PENDING 12
`define HISC_ST_SB_FREE 13
`define HISC_ST_REQ_RESP 14
`define HISC_ST_ADAPTER_CMD 15

// Bits cleared by a read of the auto-acknowledge copy
`define HISC_AUTO_ACK_MASK 16'he645
// Bits that can raise the interrupt line (pending bit excluded)
`define HISC_INT_SRC_MASK 16'hefce
`define HISC_STATUS_RESET 16'h0000

// ==========================================
// MAC status bit positions
`define HISC_MS_FW_FATAL 14
`define HISC_MS_WATCHDOG 3
`define HISC_MS_PROT_WR 2
`define HISC_MS_RESET 16'h00c0
`define HISC_MS_WR_MASK 16'h7eff
`define HISC_MAILBOX_RESET 8'h00
`define HISC_PROT_WE_BIT 6

// ==========================================
// Command field layout and codes
`define HISC_CMD_CODE_LSB 11
`define HISC_CMD_GLOBAL_RESET 5'h00
`define HISC_CMD_UP_RESET 5'h05
`define HISC_CMD_DN_RESET 5'h0b
`define HISC_CMD_ACK_INT 5'h0d
`define HISC_CMD_INT_REQUEST 5'h0c
`define HISC_CMD_SET_INT_EN 5'h0e
`define HISC_CMD_SET_INT_EN2 5'h0f
`define HISC_CMD_HOST_KEEP_BIT 5
`define HISC_CMD_DN_KEEP_BIT 8

`endif

// ---- rtl/hisc_pkg.sv ----
// Types shared by the interrupt status and command front end
// Assumes the constant header is on the include path
package hisc_pkg;

	// Host register access presented by the host bus interface
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [1:0] be;
		logic [15:0] wdata;
	} hisc_host_req_s;

	// Local bus access to card-side registers
	typedef struct packed {
		logic rd;
		logic wr;
		logic from_host;
		logic [23:0] addr;
		logic [15:0] wdata;
	} hisc_loc_req_s;

	// Mailbox operation taken from address bits
	typedef enum logic [1:0] {
		HISC_MB_PLAIN,
		HISC_MB_CLEAR,
		HISC_MB_SET,
		HISC_MB_UNDEF
	} hisc_mb_op_e;

	// Long-command sequencer states
	typedef enum logic [1:0] {
		HISC_SQ_IDLE,
		HISC_SQ_BUSY,
		HISC_SQ_DONE
	} hisc_seq_e;

endpackage

// ---- rtl/hisc_mailbox.sv ----
// Mailbox interrupt register with address-encoded read, write, set and clear
// Assumes local bus strobes are one-cycle pulses on the system clock
`timescale 1ns/100ps
`include "hisc_regs.svh"

module hisc_mailbox (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Access
	input wire logic sel_i,
	input wire logic wr_i,
	input wire hisc_pkg::hisc_mb_op_e op_i,
	input wire logic [7:0] wdata_i,
	// Processor-side clears of handled bits
	input wire logic [7:0] proc_clr_i,
	// Contents
	output logic [7:0] mailbox_o
);

	logic [7:0] mailbox_r;
	logic [7:0] mailbox_nxt;

	// Next value; reads never change contents, undefined op is ignored
	always_comb begin
		mailbox_nxt = mailbox_r & ~proc_clr_i;
		if (sel_i && wr_i) begin
			case (op_i)
				// RQ11 plain write
				hisc_pkg::HISC_MB_PLAIN: mailbox_nxt = wdata_i;
				// RQ12 clear by AND
				hisc_pkg::HISC_MB_CLEAR: mailbox_nxt = mailbox_r & wdata_i;
				// RQ13 set by OR; host sets win over processor clears
				hisc_pkg::HISC_MB_SET: mailbox_nxt = (mailbox_r & ~proc_clr_i) | wdata_i;
				default: mailbox_nxt = mailbox_r & ~proc_clr_i;
			endcase
		end
	end

	// Register
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mailbox_r <= `HISC_MAILBOX_RESET;
		end else if (ce_i) begin
			mailbox_r <= mailbox_nxt;
		end
	end

	assign mailbox_o = mailbox_r;

endmodule

// ---- rtl/hisc_top.sv ----
// Host interrupt status, auto-acknowledge, command and mailbox front end
// Assumes host and local accesses are one-cycle strobes on the system clock
// Overview of operation
// RQ1 - Download-indicated completion sets bit 9
// RQ2 - Upload completion sets bit 10
// RQ3 - Processor sets underrun bit; download reset clears
// RQ4 - Bit 12 high while command executes
// RQ5 - Processor sets status-block-free bit 13
// RQ6 - Processor sets request-response bit 14
// RQ7 - Processor sets adapter-command bit 15
// RQ8 - Auto-ack copy reads same as status
// RQ9 - Auto-ack read clears interrupt mask
// RQ10 - Auto-ack read clears listed status bits
// RQ11 - Mailbox op from local address bits 6:5
// RQ12 - Clear write: zero bits clear
// RQ13 - Set write: one bits set
// RQ14 - Host uses set op for mailbox signals
// RQ15 - Busy-block requests answered by free interrupts
// RQ16 - Firmware fatal bit 14, watchdog bit 3
// RQ17 - Protected write sets bit 2 unless enabled
// RQ18 - Host never writes MAC status
// RQ19 - Command shares 5E: code 15:11, parameter
// RQ20 - Byte write to upper byte allowed
// RQ21 - Don't-care command bits ignored
// RQ22 - Short commands finish in one cycle
// RQ23 - Latch bit is OR of masked sources
// RQ24 - MAC fault set from MAC bits 14,3,2
// RQ25 - Pending raised on accept, dropped on finish
// RQ26 - Set or clear op reads leave mailbox
`timescale 1ns/100ps
`include "hisc_regs.svh"

module hisc_top (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Host register access
	input wire hisc_pkg::hisc_host_req_s host_req_i,
	output logic [15:0] host_rdata_o,
	output logic host_irq_o,
	// Local bus access (host window and processor)
	input wire hisc_pkg::hisc_loc_req_s loc_req_i,
	output logic [15:0] loc_rdata_o,
	// Processor attention register, memory write enable inside
	input wire logic [7:0] processor_attention_i,
	input wire logic prot_target_i,
	// Data path events
	input wire logic download_done_i,
	input wire logic download_indicate_request_i,
	input wire logic upload_done_i,
	input wire logic tx_done_i,
	input wire logic host_error_i,
	input wire logic tx_underrun_i,
	input wire logic watchdog_expired_i,
	// Processor status settings
	input wire logic proc_starved_set_i,
	input wire logic proc_sb_free_set_i,
	input wire logic proc_req_resp_set_i,
	input wire logic proc_adapter_cmd_set_i,
	input wire logic [7:0] proc_mailbox_clr_i,
	// Long command completion from the engines
	input wire logic long_cmd_done_i,
	// Datapath control
	output logic tx_halt_o,
	output logic download_stall_o,
	output logic [7:0] processor_mailbox_interrupt_o,
	output logic cmd_strobe_o,
	output logic [4:0] cmd_code_o,
	output logic [10:0] cmd_param_o
);

	// ==========================================
	// Declarations
	logic [15:0] status_r;
	logic [15:0] status_nxt;
	logic [15:0] interrupt_mask_r;
	logic [15:0] mac_error_status_r;
	logic [15:0] mac_nxt;
	logic [15:0] host_rdata_r;
	logic [15:0] loc_rdata_r;
	logic tx_halt_r;
	logic cmd_strobe_r;
	logic [4:0] cmd_code_r;
	logic [10:0] cmd_param_r;
	hisc_pkg::hisc_seq_e seq_r;
	logic [15:0] status_view;
	logic [15:0] cmd_word;
	logic [4:0] code;
	logic cmd_wr;
	logic auto_rd;
	logic is_ack;
	logic is_long;
	logic host_keep;
	logic dn_keep;
	logic mb_sel;
	logic mac_sel;
	logic [7:0] mailbox;
	logic prot_viol;
	hisc_pkg::hisc_mb_op_e mb_op;

	// ==========================================
	// Command decode
	// RQ19 command shares status offset; RQ20 upper-byte write accepted, low byte zero
	assign cmd_wr = host_req_i.wr && host_req_i.be[1] && (host_req_i.addr == `HISC_OFS_STATUS_CMD);
	assign cmd_word = {host_req_i.wdata[15:8], host_req_i.be[0] ? host_req_i.wdata[7:0] : 8'h00};
	assign code = cmd_word[15:`HISC_CMD_CODE_LSB];
	assign is_ack = cmd_wr && (code == `HISC_CMD_ACK_INT);
	// RQ22 only resets run long, all others finish at once
	assign is_long = cmd_wr && ((code == `HISC_CMD_GLOBAL_RESET) || (code == `HISC_CMD_DN_RESET)
		|| (code == `HISC_CMD_UP_RESET));
	assign host_keep = cmd_word[`HISC_CMD_HOST_KEEP_BIT];
	assign dn_keep = cmd_word[`HISC_CMD_DN_KEEP_BIT];
	// RQ8 same layout on the auto-acknowledge copy
	assign auto_rd = host_req_i.rd && (host_req_i.addr == `HISC_OFS_AUTO_ACK);

	// ==========================================
	// Status view and interrupt line
	always_comb begin
		status_view = status_r;
		status_view[`HISC_ST_PENDING] = (seq_r == hisc_pkg::HISC_SQ_BUSY);
		// RQ24 fault reads the latched status bit, held until a global reset
		status_view[`HISC_ST_MAC_FAULT] = status_r[`HISC_ST_MAC_FAULT];
	end

	// ==========================================
	// Interrupt status flags; hardware sets win over acknowledges
	always_comb begin
		status_nxt = status_r;
		if (is_ack) begin
			// RQ21 don't-care positions of the mask are unused
			status_nxt = status_nxt & ~({cmd_word[10:0], 5'h00} & 16'he644
				| {15'h0000, cmd_word[0]});
		end
		// RQ10 auto-acknowledge read clears the listed bits
		if (auto_rd) begin
			status_nxt = status_nxt & ~`HISC_AUTO_ACK_MASK;
		end
		// RQ3 download reset clears the underrun indication
		if (is_long && (code == `HISC_CMD_DN_RESET) && !dn_keep) begin
			status_nxt[`HISC_ST_STARVED] = 1'b0;
		end
		if (is_long && (code == `HISC_CMD_GLOBAL_RESET) && !host_keep) begin
			status_nxt = `HISC_STATUS_RESET;
		end
		// RQ1 download completion with indication requested
		if (download_done_i && download_indicate_request_i) begin
			status_nxt[`HISC_ST_DOWNLOAD] = 1'b1;
		end
		// RQ2 upload completion
		if (upload_done_i) begin
			status_nxt[`HISC_ST_UPLOAD] = 1'b1;
		end
		if (tx_done_i) begin
			status_nxt[`HISC_ST_TX_DONE] = 1'b1;
		end
		if (host_error_i) begin
			status_nxt[`HISC_ST_HOST_ERR] = 1'b1;
		end
		if (cmd_wr && (code == `HISC_CMD_INT_REQUEST)) begin
			status_nxt[`HISC_ST_INT_REQ] = 1'b1;
		end
		// RQ3 processor shows underrun once path is restored
		if (proc_starved_set_i) begin
			status_nxt[`HISC_ST_STARVED] = 1'b1;
		end
		// RQ5 RQ15 status block consumed
		if (proc_sb_free_set_i) begin
			status_nxt[`HISC_ST_SB_FREE] = 1'b1;
		end
		// RQ6 request block return code written
		if (proc_req_resp_set_i) begin
			status_nxt[`HISC_ST_REQ_RESP] = 1'b1;
		end
		// RQ7 adapter request block holds a command
		if (proc_adapter_cmd_set_i) begin
			status_nxt[`HISC_ST_ADAPTER_CMD] = 1'b1;
		end
		// RQ24 only a global reset acknowledges the MAC fault
		if ((|(mac_error_status_r & 16'h400c) || status_r[`HISC_ST_MAC_FAULT])
			&& !(is_long && (code == `HISC_CMD_GLOBAL_RESET))) begin
			status_nxt[`HISC_ST_MAC_FAULT] = 1'b1;
		end else begin
			status_nxt[`HISC_ST_MAC_FAULT] = 1'b0;
		end
		// RQ23 latch is OR of masked sources after acks; auto-ack read empties the mask
		if (!auto_rd && |(status_nxt & interrupt_mask_r & `HISC_INT_SRC_MASK)) begin
			status_nxt[`HISC_ST_LATCH] = 1'b1;
		end
		status_nxt[`HISC_ST_PENDING] = 1'b0;
	end

	// Status register
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			status_r <= `HISC_STATUS_RESET;
		end else if (ce_i) begin
			status_r <= status_nxt;
		end
	end

	// ==========================================
	// Interrupt mask
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			interrupt_mask_r <= 16'h0000;
		end else if (ce_i) begin
			// RQ9 auto-acknowledge read clears the whole mask
			if (auto_rd) begin
				interrupt_mask_r <= 16'h0000;
			end else if (cmd_wr && ((code == `HISC_CMD_SET_INT_EN)
				|| (code == `HISC_CMD_SET_INT_EN2))) begin
				interrupt_mask_r <= {4'h0, cmd_word[11:0]};
			end else if (is_long && (code == `HISC_CMD_GLOBAL_RESET) && !host_keep) begin
				interrupt_mask_r <= 16'h0000;
			end
		end
	end

	// ==========================================
	// Long command sequencer
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seq_r <= hisc_pkg::HISC_SQ_IDLE;
		end else if (ce_i) begin
			case (seq_r)
				// RQ25 pending raised on accept of a long command
				hisc_pkg::HISC_SQ_IDLE: begin
					if (is_long) begin
						seq_r <= hisc_pkg::HISC_SQ_BUSY;
					end
				end
				// RQ4 held until the engine reports finish
				hisc_pkg::HISC_SQ_BUSY: begin
					if (long_cmd_done_i) begin
						seq_r <= hisc_pkg::HISC_SQ_DONE;
					end
				end
				// Pending already reads zero here, so a new long command is legal
				hisc_pkg::HISC_SQ_DONE: begin
					seq_r <= is_long ? hisc_pkg::HISC_SQ_BUSY : hisc_pkg::HISC_SQ_IDLE;
				end
				default: seq_r <= hisc_pkg::HISC_SQ_IDLE;
			endcase
		end
	end

	// Command strobe to the engines
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_strobe_r <= 1'b0;
			cmd_code_r <= 5'h00;
			cmd_param_r <= 11'h000;
		end else if (ce_i) begin
			cmd_strobe_r <= cmd_wr;
			if (cmd_wr) begin
				cmd_code_r <= code;
				cmd_param_r <= cmd_word[10:0];
			end
		end
	end

	// ==========================================
	// Transmit halt on underrun
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_halt_r <= 1'b0;
		end else if (ce_i) begin
			// RQ3 halt and stall until a download reset
			if (tx_underrun_i) begin
				tx_halt_r <= 1'b1;
			end else if (is_long && (code == `HISC_CMD_DN_RESET) && !dn_keep) begin
				tx_halt_r <= 1'b0;
			end
		end
	end

	// ==========================================
	// Local bus decode
	assign mb_op = hisc_pkg::hisc_mb_op_e'(loc_req_i.addr[`HISC_LOC_OP_LSB +: 2]);
	assign mb_sel = ((loc_req_i.addr & `HISC_LOC_MAILBOX_MASK) == `HISC_LOC_MAILBOX);
	assign mac_sel = (loc_req_i.addr == `HISC_LOC_MAC_STATUS);
	// RQ17 protected write unless write enable is set
	assign prot_viol = loc_req_i.wr && loc_req_i.from_host && prot_target_i
		&& !processor_attention_i[`HISC_PROT_WE_BIT];

	// RQ11 mailbox with address-encoded operation
	hisc_mailbox u_mailbox (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.sel_i(mb_sel),
		.wr_i(loc_req_i.wr),
		.op_i(mb_op),
		.wdata_i(loc_req_i.wdata[7:0]),
		.proc_clr_i(proc_mailbox_clr_i),
		.mailbox_o(mailbox)
	);

	// ==========================================
	// MAC error status; hardware sets win over firmware writes
	always_comb begin
		mac_nxt = mac_error_status_r;
		// RQ16 firmware writes, bridge bits 15 and 8 untouched
		if (mac_sel && loc_req_i.wr && !loc_req_i.from_host) begin
			mac_nxt = (loc_req_i.wdata & `HISC_MS_WR_MASK)
				| (mac_error_status_r & ~`HISC_MS_WR_MASK);
		end
		// RQ16 watchdog expiry
		if (watchdog_expired_i) begin
			mac_nxt[`HISC_MS_WATCHDOG] = 1'b1;
		end
		// RQ17 protected write violation
		if (prot_viol) begin
			mac_nxt[`HISC_MS_PROT_WR] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mac_error_status_r <= `HISC_MS_RESET;
		end else if (ce_i) begin
			if (is_long && (code == `HISC_CMD_GLOBAL_RESET)) begin
				mac_error_status_r <= `HISC_MS_RESET;
			end else begin
				mac_error_status_r <= mac_nxt;
			end
		end
	end

	// ==========================================
	// Read data
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			host_rdata_r <= 16'h0000;
			loc_rdata_r <= 16'h0000;
		end else if (ce_i) begin
			if (host_req_i.rd) begin
				case (host_req_i.addr)
					`HISC_OFS_STATUS_CMD: host_rdata_r <= status_view;
					`HISC_OFS_AUTO_ACK: host_rdata_r <= status_view;
					`HISC_OFS_INT_MASK: host_rdata_r <= interrupt_mask_r;
					default: host_rdata_r <= 16'h0000;
				endcase
			end
			if (loc_req_i.rd) begin
				// RQ26 set or clear op reads return zero
				if (mb_sel) begin
					loc_rdata_r <= (mb_op == hisc_pkg::HISC_MB_PLAIN) ? {8'h00, mailbox} : 16'h0000;
				end else if (mac_sel) begin
					loc_rdata_r <= mac_error_status_r;
				end else begin
					loc_rdata_r <= 16'h0000;
				end
			end
		end
	end

	// ==========================================
	// Outputs
	assign host_rdata_o = host_rdata_r;
	assign loc_rdata_o = loc_rdata_r;
	// Latch holds the line until acknowledged
	assign host_irq_o = status_r[`HISC_ST_LATCH];
	assign tx_halt_o = tx_halt_r;
	assign download_stall_o = tx_halt_r;
	assign processor_mailbox_interrupt_o = mailbox;
	assign cmd_strobe_o = cmd_strobe_r;
	assign cmd_code_o = cmd_code_r;
	assign cmd_param_o = cmd_param_r;

endmodule

// ---- verif/hisc_top_checker.sv ----
// Port-level checker for the interrupt status and command front end
// Assumes one clock domain and the bind in the bench top file
`timescale 1ns/100ps
`include "hisc_regs.svh"
module hisc_top_checker (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Host and local side
	input wire hisc_pkg::hisc_host_req_s host_req_i,
	input wire logic [15:0] host_rdata_o,
	input wire logic host_irq_o,
	input wire hisc_pkg::hisc_loc_req_s loc_req_i,
	input wire logic [7:0] proc_mailbox_clr_i,
	input wire logic tx_underrun_i,
	// Outputs under watch
	input wire logic tx_halt_o,
	input wire logic download_stall_o,
	input wire logic [7:0] processor_mailbox_interrupt_o,
	input wire logic cmd_strobe_o,
	input wire logic [4:0] cmd_code_o,
	input wire logic [10:0] cmd_param_o
);
	// ==========
	// Decode helpers
	logic cw, mm, qc;
	logic [1:0] op;
	logic [7:0] mo, wd;
	assign cw = host_req_i.wr && host_req_i.addr == `HISC_OFS_STATUS_CMD && host_req_i.be[1];
	assign mm = (loc_req_i.addr & `HISC_LOC_MAILBOX_MASK) == `HISC_LOC_MAILBOX;
	assign qc = proc_mailbox_clr_i == 8'h00;
	assign op = loc_req_i.addr[6:5];
	assign mo = processor_mailbox_interrupt_o;
	assign wd = loc_req_i.wdata[7:0];
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	// ==========
	// Command register
	AST_CMD_CODE: assert property (cw |=> cmd_strobe_o && cmd_code_o == $past(host_req_i.wdata[15:11]))
		else $error("command code wrong");
	AST_CMD_PARAM: assert property (cw && host_req_i.be[0] |=> cmd_param_o == $past(host_req_i.wdata[10:0]))
		else $error("command parameter wrong");
	AST_CMD_BYTE: assert property (cw && !host_req_i.be[0] |=> cmd_param_o[7:0] == 8'h00)
		else $error("upper byte write kept low byte");
	AST_STROBE_CAUSE: assert property (cmd_strobe_o |-> $past(cw))
		else $error("strobe without command write");
	AST_RD_LATCH: assert property (host_req_i.rd && host_req_i.addr[7:4] == 4'h5 && host_req_i.addr[3:0] inside {4'h6, 4'he} |=> host_rdata_o[0] == $past(host_irq_o))
		else $error("latch bit differs from interrupt line");
	// ==========
	// Mailbox and transmit halt
	AST_MB_PLAIN: assert property (loc_req_i.wr && mm && op == 2'b00 && qc |=> mo == $past(wd))
		else $error("plain mailbox write lost");
	AST_MB_CLR: assert property (loc_req_i.wr && mm && op == 2'b01 |=> (mo & ~$past(wd)) == 8'h00)
		else $error("clear write left a bit");
	AST_MB_SET: assert property (loc_req_i.wr && mm && op == 2'b10 |=> (mo & $past(wd)) == $past(wd))
		else $error("set write missed a bit");
	AST_MB_UNDEF: assert property (loc_req_i.wr && mm && op == 2'b11 && qc |=> mo == $past(mo))
		else $error("undefined op changed mailbox");
	AST_MB_KEEP: assert property (loc_req_i.rd && !loc_req_i.wr && mm && op != 2'b00 && qc |=> $stable(mo))
		else $error("mailbox read changed contents");
	AST_TX_HALT: assert property (tx_underrun_i |=> tx_halt_o && download_stall_o)
		else $error("underrun did not halt");
	// Main scenarios reached
	cover property (cmd_strobe_o && cmd_code_o == `HISC_CMD_DN_RESET);
	cover property (host_irq_o);
	cover property (loc_req_i.wr && mm && op == 2'b10);
endmodule

// ---- verif/hisc_proc_model.sv ----
// Model of the processor and engines beyond the front end
// Assumes it sees the design's command strobe and mailbox contents
`timescale 1ns/100ps
`include "hisc_regs.svh"
module hisc_proc_model #(
	parameter int LAT = 4
) (
	// Clock, reset, answer speed
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic slow_i,
	// From the design
	input wire logic cmd_strobe_o,
	input wire logic [4:0] cmd_code_o,
	input wire logic [7:0] processor_mailbox_interrupt_o,
	// To the design
	output logic long_cmd_done_o,
	output logic sb_free_set_o,
	output logic req_resp_set_o,
	output logic [7:0] mailbox_clr_o
);
	int lc;
	int c [2];
	logic [1:0] set_r;
	// ==========
	// only reset codes take long
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lc <= 0;
			long_cmd_done_o <= 1'b0;
		end else begin
			long_cmd_done_o <= lc == 1;
			if (cmd_strobe_o && cmd_code_o inside {`HISC_CMD_GLOBAL_RESET, `HISC_CMD_UP_RESET,
				`HISC_CMD_DN_RESET}) begin
				lc <= slow_i ? 4 * LAT : LAT;
			end else if (lc > 0) begin
				lc <= lc - 1;
			end
		end
	end
	// answer block requests
	// The just-sent clear blocks a restart while the mailbox bit drains
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			c <= '{0, 0};
			set_r <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				set_r[i] <= c[i] == 1;
				if (c[i] > 0) begin
					c[i] <= c[i] - 1;
				end else if (processor_mailbox_interrupt_o[i + 2] && !set_r[i]) begin
					c[i] <= slow_i ? 4 * LAT : LAT;
				end
			end
		end
	end
	// Answer and clear leave together
	assign sb_free_set_o = set_r[0];
	assign req_resp_set_o = set_r[1];
	assign mailbox_clr_o = {4'h0, set_r, 2'b00};
endmodule

// ---- verif/host_interrupt_status_and_command_tb_top.sv ----
// Self-checking bench for the interrupt status and command front end
// Assumes the processor model and the checker beside it
`timescale 1ns/100ps
`include "hisc_regs.svh"
module host_interrupt_status_and_command_tb_top;
	localparam logic [23:0] MBP = 24'hcde0b, MBC = 24'hcde2b, MBS = 24'hcde4b, MBU = 24'hcde6b;
	localparam logic [23:0] MAC = `HISC_LOC_MAC_STATUS;
	localparam logic [15:0] MW = `HISC_MS_WR_MASK;
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	hisc_pkg::hisc_host_req_s hq = '0;
	hisc_pkg::hisc_loc_req_s lq = '0;
	logic [7:0] att = 8'h00;
	logic prot = 1'b0;
	logic slow = 1'b0;
	logic [8:0] ev = 9'h000;
	logic [15:0] hrd, lrd, w;
	logic irq, halt, stall, stb, done, sbf, rrs, hr_d, lr_d;
	logic [7:0] mbo, mclr, d, x, m;
	logic [4:0] code;
	logic [10:0] par;
	logic [31:0] e;
	logic [31:0] rq [$];
	logic [31:0] lqq [$];
	logic [15:0] cq [$];
	logic [4:0] cc [4] = '{5'h13, 5'h18, 5'h06, 5'h09};
	int n_fail = 0;
	int checks_done = 0;
	int seed = 44;
	// ==========
	// Clock, design and processor model
	initial begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	hisc_top dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1), .host_req_i(hq),
		.host_rdata_o(hrd), .host_irq_o(irq), .loc_req_i(lq), .loc_rdata_o(lrd),
		.processor_attention_i(att), .prot_target_i(prot), .download_done_i(ev[0]),
		.download_indicate_request_i(ev[1]), .upload_done_i(ev[2]), .tx_done_i(ev[3]),
		.host_error_i(ev[4]), .tx_underrun_i(ev[5]), .watchdog_expired_i(ev[6]),
		.proc_starved_set_i(ev[7]), .proc_sb_free_set_i(sbf), .proc_req_resp_set_i(rrs),
		.proc_adapter_cmd_set_i(ev[8]), .proc_mailbox_clr_i(mclr), .long_cmd_done_i(done),
		.tx_halt_o(halt), .download_stall_o(stall), .processor_mailbox_interrupt_o(mbo),
		.cmd_strobe_o(stb), .cmd_code_o(code), .cmd_param_o(par));
	hisc_proc_model #(.LAT(4)) pm (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .slow_i(slow),
		.cmd_strobe_o(stb), .cmd_code_o(code), .processor_mailbox_interrupt_o(mbo),
		.long_cmd_done_o(done), .sb_free_set_o(sbf), .req_resp_set_o(rrs), .mailbox_clr_o(mclr));
	// ==========
	// Compare, bus cycles and pulses
	task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] gt,
		input logic [15:0] mk);
		checks_done++;
		if ((gt & mk) !== (ex & mk)) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, ex & mk, gt & mk);
		end
	endtask
	task automatic hbus(input logic r, input logic [7:0] a, input logic [1:0] b,
		input logic [15:0] wd, input logic [15:0] ex, input logic [15:0] mk);
		@(posedge clk_sys_i);
		hq <= '{r, !r, a, b, wd};
		if (r) begin
			rq.push_back({mk, ex});
		end else if (a == `HISC_OFS_STATUS_CMD && b[1]) begin
			cq.push_back(b[0] ? wd : {wd[15:8], 8'h00});
		end
		@(posedge clk_sys_i);
		hq <= '0;
	endtask
	task automatic lbus(input logic r, input logic [23:0] a, input logic [15:0] wd,
		input logic fh, input logic [15:0] ex, input logic [15:0] mk);
		@(posedge clk_sys_i);
		lq <= '{r, !r, fh, a, wd};
		if (r) begin
			lqq.push_back({mk, ex});
		end
		@(posedge clk_sys_i);
		lq <= '0;
	endtask
	task automatic pls(input logic [8:0] v);
		@(posedge clk_sys_i);
		ev <= v;
		@(posedge clk_sys_i);
		ev <= 9'h000;
		@(posedge clk_sys_i);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Results taken in arrival order; a stray strobe meets an unknown note
	always @(posedge clk_sys_i) begin
		hr_d <= hq.rd;
		lr_d <= lq.rd;
		if (hr_d) begin
			e = rq.pop_front();
			chk("host_rdata", e[15:0], hrd, e[31:16]);
		end
		if (lr_d) begin
			e = lqq.pop_front();
			chk("loc_rdata", e[15:0], lrd, e[31:16]);
		end
		if (stb) begin
			w = cq.size() > 0 ? cq.pop_front() : 16'hxxxx;
			chk("command", w, {code, par}, 16'hffff);
		end
	end
	// Cut a hang short
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_fail++;
		end_sim;
	end
	// ==========
	// Scenarios
	initial begin
		repeat (12) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		hbus(1, 8'h5e, 0, 0, 16'h0000, 16'hffff);
		hbus(1, 8'h40, 0, 0, 16'h0000, 16'hffff);
		lbus(1, MAC, 0, 0, `HISC_MS_RESET, MW);
		pls(9'h001);
		hbus(1, 8'h5e, 0, 0, 16'h0000, 16'h0200);
		pls(9'h18f);
		lbus(0, MBS, 16'h000c, 1, 0, 0);
		repeat (30) @(posedge clk_sys_i);
		hbus(1, 8'h5e, 0, 0, 16'hee04, 16'hffff);
		lbus(1, MBP, 0, 1, 16'h0000, 16'h000c);
		hbus(1, 8'h56, 0, 0, 16'hee04, 16'hffff);
		hbus(1, 8'h5e, 0, 0, 16'h0800, 16'hffff);
		pls(9'h020);
		chk("halt", 16'h0003, {14'h0, halt, stall}, 16'h0003);
		slow <= 1'b1;
		hbus(0, 8'h5e, 2'b11, 16'h5800, 0, 0);
		hbus(1, 8'h5e, 0, 0, 16'h1000, 16'h1000);
		repeat (40) @(posedge clk_sys_i);
		hbus(1, 8'h5e, 0, 0, 16'h0000, 16'hffff);
		chk("halt", 16'h0000, {15'h0, halt}, 16'h0001);
		slow <= 1'b0;
		hbus(0, 8'h5e, 2'b11, 16'h7fff, 0, 0);
		pls(9'h004);
		chk("irq", 16'h0001, {15'h0, irq}, 16'h0001);
		hbus(1, 8'h56, 0, 0, 16'h0401, 16'h0401);
		hbus(1, 8'h5a, 0, 0, 16'h0000, 16'hffff);
		hbus(0, 8'h5e, 2'b11, 16'h6801, 0, 0);
		pls(9'h004);
		chk("irq", 16'h0000, {15'h0, irq}, 16'h0001);
		hbus(1, 8'h56, 0, 0, 16'h0400, 16'h0400);
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed)) & 8'hf3;
			x = 8'($random(seed));
			m = 8'($random(seed)) & 8'hf3;
			lbus(0, MBP, {8'h00, d}, 1, 0, 0);
			lbus(0, MBC, {8'h00, x}, 1, 0, 0);
			lbus(1, MBC, 0, 1, 0, 0);
			lbus(0, MBS, {8'h00, m}, 1, 0, 0);
			lbus(0, MBU, 16'h00ff, 1, 0, 0);
			lbus(1, MBP, 0, 1, {8'h00, (d & x) | m}, 16'h00ff);
		end
		pls(9'h040);
		lbus(1, MAC, 0, 0, 16'h00c8, MW);
		hbus(1, 8'h5e, 0, 0, 16'h0080, 16'h0080);
		att <= 8'h40;
		prot <= 1'b1;
		lbus(0, 24'h001000, 16'h1234, 1, 0, 0);
		lbus(1, MAC, 0, 0, 16'h00c8, MW);
		att <= 8'hbf;
		lbus(0, 24'h001000, 16'h1234, 1, 0, 0);
		lbus(1, MAC, 0, 0, 16'h00cc, MW);
		prot <= 1'b0;
		lbus(0, MAC, 16'h40cc, 0, 0, 0);
		lbus(1, MAC, 0, 0, 16'h40cc, MW);
		hbus(0, 8'h5e, 2'b11, 16'h0000, 0, 0);
		repeat (20) @(posedge clk_sys_i);
		hbus(1, 8'h5e, 0, 0, 16'h0000, 16'hffff);
		lbus(1, MAC, 0, 0, `HISC_MS_RESET, MW);
		foreach (cc[i]) begin
			w = {cc[i], 11'h000} | (16'($random(seed)) & 16'h07ff);
			hbus(0, 8'h5e, 2'b11, w, 0, 0);
		end
		hbus(0, 8'h5e, 2'b10, 16'h60ff, 0, 0);
		hbus(1, 8'h5e, 0, 0, 16'h0040, 16'h0040);
		hbus(0, 8'h5c, 2'b11, 16'h6801, 0, 0);
		repeat (4) @(posedge clk_sys_i);
		end_sim;
	end
endmodule
bind hisc_top hisc_top_checker chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
	.host_req_i(host_req_i), .host_rdata_o(host_rdata_o), .host_irq_o(host_irq_o),
	.loc_req_i(loc_req_i), .proc_mailbox_clr_i(proc_mailbox_clr_i),
	.tx_underrun_i(tx_underrun_i), .tx_halt_o(tx_halt_o), .download_stall_o(download_stall_o),
	.processor_mailbox_interrupt_o(processor_mailbox_interrupt_o), .cmd_strobe_o(cmd_strobe_o),
	.cmd_code_o(cmd_code_o), .cmd_param_o(cmd_param_o));
